/* File: bbsp_host.v */
/*
 Host-side controller driving an 8K x 8 asynchronous static memory with a
 power-fail indication. Turns one-cycle read and write requests into pin
 sequences with the memory's timing. Assumes the memory pins connect
 directly and the supply-fail level arrives asynchronously. Requests
 come from logic on CORE_CLK and need no synchroniser.
*/
`timescale 1ns/10ps
`default_nettype none
`include "bbsp_regs.vh"
module bbsp_host #(
    parameter ADDR_W = `BBSP_ADDR_W,
    parameter DATA_W = `BBSP_DATA_W,
    parameter RECOVERY_CYC = `BBSP_RECOVERY_CYC
) (
    input wire CORE_CLK,
    input wire RESET,
    input wire REQ_VALID,
    input wire REQ_WRITE,
    input wire [ADDR_W-1:0] REQ_ADDR,
    input wire [DATA_W-1:0] REQ_WDATA,
    output wire REQ_READY,
    output reg RSP_VALID,
    output reg [DATA_W-1:0] RSP_RDATA,
    output wire MEM_ONLINE,
    input wire SUPPLY_FAIL,
    output reg [ADDR_W-1:0] BYTE_LOCATION,
    output reg SELECT_N,
    output reg DRIVE_N,
    output reg STROBE_N,
    input wire [DATA_W-1:0] BYTE_LANE_I,
    output reg [DATA_W-1:0] BYTE_LANE_O,
    output reg BYTE_LANE_OE
);
    localparam ST_RECOVER = 3'h0;
    localparam ST_IDLE = 3'h1;
    localparam ST_READ = 3'h2;
    localparam ST_FLOAT = 3'h3;
    localparam ST_WRITE = 3'h4;
    localparam ST_HOLD = 3'h5;
    // The counter is sized for the full recovery interval at the core clock.
    localparam CNT_W = 24;

    function [CNT_W-1:0] cyc;
        input integer n;
        begin
            cyc = n[CNT_W-1:0];
        end
    endfunction

    // True on the last cycle of a timed phase; a load of zero also ends at once.
    function cnt_done;
        input [CNT_W-1:0] c;
        begin
            cnt_done = (c <= cyc(1));
        end
    endfunction

    // One step down of the phase counter, shared by every timed state.
    function [CNT_W-1:0] cnt_dec;
        input [CNT_W-1:0] c;
        begin
            cnt_dec = c - cyc(1);
        end
    endfunction

    reg [2:0] state_reg;
    reg [CNT_W-1:0] cnt_reg;
    reg [DATA_W-1:0] lane_s1_reg;
    reg [DATA_W-1:0] lane_s2_reg;
    wire fail_sync;

    // The fail level is treated as pessimistic: reset assumes power is down.
    bbsp_sync #(.RESET_VAL(1'b1)) u_fail_sync (
        .clk(CORE_CLK),
        .rst(RESET),
        .d(SUPPLY_FAIL),
        .q(fail_sync)
    );

    // Ready falls with the synchronised fail level, so no request is taken then.
    assign REQ_READY = (state_reg == ST_IDLE) && !fail_sync;
    assign MEM_ONLINE = (state_reg != ST_RECOVER);

    // The lane is sampled through two stages; the read count allows for them.
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            lane_s1_reg <= 8'h00;
            lane_s2_reg <= 8'h00;
        end else begin
            lane_s1_reg <= BYTE_LANE_I;
            lane_s2_reg <= lane_s1_reg;
        end
    end

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            state_reg <= ST_RECOVER;
            cnt_reg <= cyc(RECOVERY_CYC);
            SELECT_N <= 1'b1;
            DRIVE_N <= 1'b1;
            STROBE_N <= 1'b1;
            BYTE_LOCATION <= 13'h0000;
            BYTE_LANE_O <= 8'h00;
            BYTE_LANE_OE <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_RDATA <= 8'h00;
        end else begin
            RSP_VALID <= 1'b0;
            if (fail_sync) begin
                // Deselect at once; an interrupted write may spoil only its byte.
                state_reg <= ST_RECOVER;
                cnt_reg <= cyc(RECOVERY_CYC);
                SELECT_N <= 1'b1;
                DRIVE_N <= 1'b1;
                STROBE_N <= 1'b1;
                BYTE_LANE_OE <= 1'b0;
            end else begin
                case (state_reg)
                    ST_RECOVER: begin
                        // Select stays high for the whole interval, so a rising supply cannot write.
                        if (cnt_done(cnt_reg)) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            cnt_reg <= cnt_dec(cnt_reg);
                        end
                    end
                    ST_IDLE: begin
                        // Requests are taken only here, so nothing queues behind a busy access.
                        if (REQ_VALID) begin
                            BYTE_LOCATION <= REQ_ADDR;
                            SELECT_N <= 1'b0;
                            if (REQ_WRITE) begin
                                // Drive stays high so the memory never fights our data.
                                STROBE_N <= 1'b0;
                                BYTE_LANE_O <= REQ_WDATA;
                                BYTE_LANE_OE <= 1'b1;
                                cnt_reg <= cyc(`BBSP_WR_CYC);
                                state_reg <= ST_WRITE;
                            end else begin
                                DRIVE_N <= 1'b0;
                                // Two extra cycles cover the pin synchroniser.
                                cnt_reg <= cyc(`BBSP_READ_CYC + 2);
                                state_reg <= ST_READ;
                            end
                        end
                    end
                    ST_READ: begin
                        if (cnt_done(cnt_reg)) begin
                            RSP_RDATA <= lane_s2_reg;
                            RSP_VALID <= 1'b1;
                            SELECT_N <= 1'b1;
                            DRIVE_N <= 1'b1;
                            // Wait for the memory to release the lane before the next access.
                            cnt_reg <= cyc(`BBSP_FLOAT_CYC);
                            state_reg <= ST_FLOAT;
                        end else begin
                            cnt_reg <= cnt_dec(cnt_reg);
                        end
                    end
                    ST_FLOAT: begin
                        // The memory may still drive the lane for its float time after deselect.
                        if (cnt_done(cnt_reg)) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            cnt_reg <= cnt_dec(cnt_reg);
                        end
                    end
                    ST_WRITE: begin
                        // Address and data held from the first edge.
                        if (cnt_done(cnt_reg)) begin
                            STROBE_N <= 1'b1;
                            SELECT_N <= 1'b1;
                            cnt_reg <= cyc(`BBSP_HOLD_CYC);
                            state_reg <= ST_HOLD;
                        end else begin
                            cnt_reg <= cnt_dec(cnt_reg);
                        end
                    end
                    ST_HOLD: begin
                        // Address and data remain one more cycle past the end edge.
                        if (cnt_done(cnt_reg)) begin
                            BYTE_LANE_OE <= 1'b0;
                            state_reg <= ST_IDLE;
                        end else begin
                            cnt_reg <= cnt_dec(cnt_reg);
                        end
                    end
                    default: begin
                        // An illegal state takes the safe path through a full recovery.
                        state_reg <= ST_RECOVER;
                        cnt_reg <= cyc(RECOVERY_CYC);
                    end
                endcase
            end
        end
    end
endmodule // bbsp_host
`default_nettype wire

/* File: bbsp_regs.vh */
/*
 Timing constants for the host-side controller of an 8K x 8 battery-backed
 static memory port. Assumes a 25 MHz core clock (40 ns period).
*/
`ifndef BBSP_REGS_VH
`define BBSP_REGS_VH
`define BBSP_CLK_PERIOD_NS 40
`define BBSP_ADDR_W 13
`define BBSP_DATA_W 8
`define BBSP_ADDR_ACCESS_NS 100
`define BBSP_DRIVE_ACCESS_NS 50
`define BBSP_STROBE_FLOAT_NS 50
`define BBSP_WR_PULSE_NS 80
`define BBSP_CYCLE_NS 100
`define BBSP_ADDR_HOLD_NS 10
`define BBSP_DATA_HOLD_NS 5
`define BBSP_RECOVERY_NS 2000000
`define BBSP_CYC_UP(ns) (((ns) + `BBSP_CLK_PERIOD_NS - 1) / `BBSP_CLK_PERIOD_NS)
`define BBSP_CYC_MIN1(ns) ((`BBSP_CYC_UP(ns) < 1) ? 1 : `BBSP_CYC_UP(ns))
`define BBSP_READ_CYC `BBSP_CYC_MIN1(`BBSP_ADDR_ACCESS_NS)
`define BBSP_FLOAT_CYC `BBSP_CYC_MIN1(`BBSP_STROBE_FLOAT_NS)
`define BBSP_WR_CYC `BBSP_CYC_MIN1(`BBSP_WR_PULSE_NS)
`define BBSP_CYCLE_CYC `BBSP_CYC_MIN1(`BBSP_CYCLE_NS)
`define BBSP_HOLD_CYC `BBSP_CYC_MIN1(`BBSP_ADDR_HOLD_NS)
`define BBSP_RECOVERY_CYC (`BBSP_RECOVERY_NS / `BBSP_CLK_PERIOD_NS)
`endif

/* File: bbsp_sync.v */
/*
 Two-flip-flop synchroniser for one level arriving from outside CORE_CLK.
 Assumes a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module bbsp_sync #(
    parameter RESET_VAL = 1'b0
) (
    input wire clk,
    input wire rst,
    input wire d,
    output reg q
);
    reg meta_reg;
    always @(posedge clk) begin
        if (rst) begin
            meta_reg <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // bbsp_sync
`default_nettype wire

/* File: bbsp_host_properties.sv */
/* Pin-timing assertions for the host memory controller.
   Assumes a bind onto bbsp_host and its single clock domain. */
`timescale 1ns/10ps
`default_nettype none
module bbsp_host_properties #(parameter ADDR_W = 13, parameter DATA_W = 8) (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic REQ_READY,
    input wire logic RSP_VALID,
    input wire logic MEM_ONLINE,
    input wire logic SUPPLY_FAIL,
    input wire logic [ADDR_W-1:0] BYTE_LOCATION,
    input wire logic SELECT_N,
    input wire logic DRIVE_N,
    input wire logic STROBE_N,
    input wire logic [DATA_W-1:0] BYTE_LANE_O,
    input wire logic BYTE_LANE_OE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    AST_READ_PINS: assert property (!DRIVE_N |-> STROBE_N && !SELECT_N && !BYTE_LANE_OE)
        else $error("host drives lane in read");
    AST_WR_SELECT: assert property (!STROBE_N |-> !SELECT_N && DRIVE_N)
        else $error("bad write strobes");
    AST_WR_PULSE: assert property ($fell(STROBE_N) |-> !STROBE_N ##1 !STROBE_N ##1 STROBE_N)
        else $error("write pulse length");
    AST_WR_ADDR: assert property ($fell(STROBE_N) |=> $stable(BYTE_LOCATION) [*2])
        else $error("address moved in write");
    AST_WR_DATA: assert property ($fell(STROBE_N) |-> BYTE_LANE_OE ##1 (BYTE_LANE_OE && $stable(BYTE_LANE_O)) [*2])
        else $error("write data not held");
    AST_READ_RSP: assert property (REQ_VALID && REQ_READY && !REQ_WRITE |-> ##6 RSP_VALID)
        else $error("read answer late");
    AST_FAIL_QUIET: assert property (SUPPLY_FAIL [*4] |-> SELECT_N && STROBE_N && !BYTE_LANE_OE && !REQ_READY)
        else $error("pins active in fail");
    AST_RECOVERY: assert property ($fell(SUPPLY_FAIL) |-> !REQ_READY [*8] ##1 !MEM_ONLINE)
        else $error("recovery too short");
endmodule // bbsp_host_properties
bind bbsp_host bbsp_host_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (.CORE_CLK(CORE_CLK),
    .RESET(RESET), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_READY(REQ_READY),
    .RSP_VALID(RSP_VALID), .MEM_ONLINE(MEM_ONLINE), .SUPPLY_FAIL(SUPPLY_FAIL),
    .BYTE_LOCATION(BYTE_LOCATION), .SELECT_N(SELECT_N), .DRIVE_N(DRIVE_N), .STROBE_N(STROBE_N),
    .BYTE_LANE_O(BYTE_LANE_O), .BYTE_LANE_OE(BYTE_LANE_OE));
`default_nettype wire

/* File: bbsp_sram_model.sv */
/* Behavioural 8K x 8 battery-backed static memory.
   Assumes the bench resolves the shared lane from both drivers. */
`timescale 1ns/10ps
`default_nettype none
module bbsp_sram_model #(parameter REC_NS = 320) (
    input wire logic [12:0] LOC,
    input wire logic SEL_N,
    input wire logic DRV_N,
    input wire logic STB_N,
    input wire logic FAIL,
    input wire logic [7:0] LANE,
    output logic [7:0] Q,
    output logic Q_EN
);
    logic [7:0] mem [0:8191];
    logic prot = 1'b0;
    logic wr_was = 1'b0;
    wire [12:0] loc_old;
    wire sel_old, drv_old;
    wire wr_on = !SEL_N && !STB_N && !prot;
    assign #100 loc_old = LOC;
    assign #100 sel_old = SEL_N;
    assign #50 drv_old = DRV_N;
    // Protection sets at once with the fail level and clears a recovery time after it drops.
    always @(FAIL) begin
        if (FAIL === 1'b1) prot = 1'b1;
        else prot <= #(REC_NS) 1'b0;
    end
    // A failing supply ends the write with a damaged byte at that one address.
    // Only a true high-to-low end commits, so the power-on settling writes nothing.
    always @(wr_on) begin
        if (wr_was === 1'b1 && wr_on !== 1'b1) mem[LOC] = FAIL ? ~LANE : LANE;
        wr_was = wr_on;
    end
    assign Q_EN = !SEL_N && !DRV_N && STB_N && !prot;
    assign Q = (loc_old === LOC && !sel_old && !drv_old) ? mem[LOC] : ~mem[LOC];
endmodule // bbsp_sram_model
`default_nettype wire

/* File: bbsp_host_tb.sv */
/* Self-checking bench for bbsp_host against the memory model.
   Assumes nothing outside these files and the design. */
`timescale 1ns/10ps
`default_nettype none
module bbsp_host_tb;
    logic clk = 1'b0, rst = 1'b1, v = 1'b0, w = 1'b0, fail = 1'b0;
    logic [12:0] a = 13'h0000;
    logic [7:0] d = 8'h00;
    wire rdy, rv, onl, sel, drv, stb, oe, qen;
    wire [12:0] loc;
    wire [7:0] rd, lo, q;
    // No pull on the lane, so an undriven lane shows a value that is surely wrong.
    wire [7:0] lane = oe ? lo : (qen ? q : ~lo);
    int errors = 0, checks_done = 0;
    initial forever #20 clk = ~clk;
    bbsp_host #(.RECOVERY_CYC(8)) u_dut (.CORE_CLK(clk), .RESET(rst), .REQ_VALID(v), .REQ_WRITE(w),
        .REQ_ADDR(a), .REQ_WDATA(d), .REQ_READY(rdy), .RSP_VALID(rv), .RSP_RDATA(rd), .MEM_ONLINE(onl),
        .SUPPLY_FAIL(fail), .BYTE_LOCATION(loc), .SELECT_N(sel), .DRIVE_N(drv), .STROBE_N(stb),
        .BYTE_LANE_I(lane), .BYTE_LANE_O(lo), .BYTE_LANE_OE(oe));
    bbsp_sram_model u_mem (.LOC(loc), .SEL_N(sel), .DRV_N(drv), .STB_N(stb), .FAIL(fail), .LANE(lane),
        .Q(q), .Q_EN(qen));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("checks=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) errors++;
    endtask
    task automatic req(input logic wr, input logic [12:0] ad, input logic [7:0] dt);
        wait_ready();
        v = 1'b1;
        w = wr;
        a = ad;
        d = dt;
        @(negedge clk) v = 1'b0;
    endtask
    task automatic rd_chk(input logic [12:0] ad, input logic [7:0] exp);
        int n;
        req(1'b0, ad, 8'h00);
        n = 0;
        while (rv !== 1'b1 && n < 20) begin
            @(posedge clk) #1;
            n++;
        end
        check({7'h00, rv}, 8'h01);
        check(rd, exp);
    endtask
    task t_rw;
        req(1'b1, 13'h0000, 8'hA5);
        req(1'b1, 13'h1FFF, 8'h5A);
        req(1'b1, 13'h0AAA, 8'h3C);
        rd_chk(13'h0000, 8'hA5);
        rd_chk(13'h1FFF, 8'h5A);
        rd_chk(13'h0AAA, 8'h3C);
    endtask
    task t_busy;
        req(1'b1, 13'h0001, 8'h11);
        check({7'h00, rdy}, 8'h00);
        rd_chk(13'h0001, 8'h11);
    endtask
    task t_fail;
        req(1'b1, 13'h0005, 8'hFF);
        fail = 1'b1;
        repeat (6) @(negedge clk);
        check({7'h00, rdy}, 8'h00);
        check({7'h00, sel}, 8'h01);
        fail = 1'b0;
        repeat (4) @(negedge clk);
        check({7'h00, onl}, 8'h00);
        rd_chk(13'h0AAA, 8'h3C);
        rd_chk(13'h1FFF, 8'h5A);
        check({7'h00, onl}, 8'h01);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk) rst = 0;
        t_rw();
        t_busy();
        t_fail();
        complete_run();
    end
endmodule // bbsp_host_tb
`default_nettype wire
